// [logic/atd_pkg.sv]
// Package: opcodes, register map, reset values and carriers for the transfer decoder
package atd_pkg;

  // ----------------------------------------------------------------
  // Opcodes (10-bit instruction words)
  // ----------------------------------------------------------------
  localparam logic [9:0] OP_LCD_THREE   = 10'h20C;
  localparam logic [9:0] OP_AUX_TIMER   = 10'h20D;
  localparam logic [9:0] OP_CLOCK_MODE  = 10'h216;
  localparam logic [9:0] OP_PRESCALER   = 10'h2AA;
  localparam logic [5:0] OP_STORE_HIGH  = 6'h2B;  // Upper six bits of store group
  localparam int         OP_IMM_LSB     = 0;
  localparam int         OP_IMM_WIDTH   = 4;

  // ----------------------------------------------------------------
  // APB register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INSTR     = 8'h00;
  localparam logic [7:0] ADDR_ACC       = 8'h04;
  localparam logic [7:0] ADDR_LCD_THREE = 8'h08;
  localparam logic [7:0] ADDR_AUX_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_AUX_RELD  = 8'h10;
  localparam logic [7:0] ADDR_CLK_MODE  = 8'h14;
  localparam logic [7:0] ADDR_PRESCALE  = 8'h18;
  localparam logic [7:0] ADDR_FILE_SEL  = 8'h1C;
  localparam logic [7:0] ADDR_DPTR      = 8'h20;
  localparam logic [7:0] ADDR_RAM_DATA  = 8'h24;
  localparam logic [7:0] ADDR_STATUS    = 8'h28;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_NIBBLE     = 4'h0;
  localparam logic [9:0] RST_INSTR      = 10'h000;
  localparam int         RAM_WORDS      = 16;

  // ----------------------------------------------------------------
  // Decoded write strobes, one per instruction kind, plus the immediate field
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       lcd_three;
    logic       aux_timer;
    logic       ram_store;
    logic       clock_mode;
    logic       prescaler;
    logic [3:0] imm;
  } atd_dec_type;

endpackage

// [logic/atd_decode.sv]
// Combinational opcode decoder for the accumulator transfer group
`timescale 1ns/1ps
`default_nettype none
module atd_decode
  import atd_pkg::*;
(
  input  wire logic [9:0] opcode,
  input  wire logic       valid,
  output var atd_dec_type dec
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // One strobe at most; a non-member opcode gives all strobes zero, imm still carries opcode[3:0]
  always_comb begin
    dec            = '0;
    dec.lcd_three  = valid && (opcode == OP_LCD_THREE);
    dec.aux_timer  = valid && (opcode == OP_AUX_TIMER);
    dec.ram_store  = valid && (opcode[9:4] == OP_STORE_HIGH);
    dec.clock_mode = valid && (opcode == OP_CLOCK_MODE);
    dec.prescaler  = valid && (opcode == OP_PRESCALER);
    dec.imm        = opcode[OP_IMM_LSB +: OP_IMM_WIDTH];
  end

endmodule
`default_nettype wire

// [logic/atd_core.sv]
// Top: APB-driven decoder and executor for accumulator transfer instructions
//
// What this block does
// - opcode 20C copies accumulator to LCD control three
// - opcode 20D writes accumulator to aux timer count
// - same cycle also loads aux timer reload
// - opcodes 2B0-2BF store accumulator at data pointer
// - same store XORs file select with j
// - opcode 216 copies accumulator to clock mode
// - clock mode register drives the clock_mode_reg output
// - opcode 2AA writes prescaler control register
// - only accumulator bit 0 reaches prescaler bit 0
`timescale 1ns/1ps
`default_nettype none
module atd_core
  import atd_pkg::*;
#(
  parameter int RAM_DEPTH = RAM_WORDS
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [3:0]  lcd_ctrl_three,
  output logic      [3:0]  aux_timer_count,
  output logic      [3:0]  aux_timer_reload,
  output logic      [3:0]  clock_mode_reg,
  output logic             prescaler_ctrl_reg,
  output logic      [3:0]  ram_file_select,
  output logic             carry_out,
  output logic             skip_next
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [3:0]  acc_r,      acc_nxt;
  logic [3:0]  lcd_r,      lcd_nxt;
  logic [3:0]  cnt_r,      cnt_nxt;
  logic [3:0]  rld_r,      rld_nxt;
  logic [3:0]  mode_r,     mode_nxt;
  logic        pre_r,      pre_nxt;
  logic [3:0]  fsel_r,     fsel_nxt;
  logic [3:0]  dptr_r,     dptr_nxt;
  logic [9:0]  instr_r,    instr_nxt;
  logic [7:0]  exec_cnt_r, exec_cnt_nxt;
  logic [3:0]  ram_r [RAM_DEPTH];
  logic [3:0]  ram_nxt [RAM_DEPTH];
  logic [31:0] prdata_r,   prdata_nxt;
  logic        err_r,      err_nxt;
  logic        exec_r,     exec_nxt;
  atd_dec_type dec;

  // ----------------------------------------------------------------
  // APB access qualifiers
  // ----------------------------------------------------------------
  // Zero-wait slave: every access phase completes at once
  logic wr_acc;
  logic addr_ok;
  assign wr_acc = psel && penable && pwrite;
  assign pready = 1'b1;
  assign addr_ok = (paddr <= ADDR_STATUS) && (paddr[1:0] == 2'b00);

  // An instruction word written over APB executes in the next cycle
  atd_decode atd_decode_i (
    .opcode (instr_r),
    .valid  (exec_r),
    .dec    (dec)
  );

  // ----------------------------------------------------------------
  // Next state: instruction issue, execution, register writes
  // ----------------------------------------------------------------
  always_comb begin
    acc_nxt      = acc_r;
    lcd_nxt      = lcd_r;
    cnt_nxt      = cnt_r;
    rld_nxt      = rld_r;
    mode_nxt     = mode_r;
    pre_nxt      = pre_r;
    fsel_nxt     = fsel_r;
    dptr_nxt     = dptr_r;
    instr_nxt    = instr_r;
    exec_nxt     = 1'b0;
    exec_cnt_nxt = exec_cnt_r;
    ram_nxt      = ram_r;
    // Execution of the previous cycle's instruction, one cycle each
    if (dec.lcd_three) begin
      lcd_nxt = acc_r;
    end
    if (dec.aux_timer) begin
      cnt_nxt = acc_r;
      rld_nxt = acc_r;
    end
    if (dec.ram_store) begin
      ram_nxt[dptr_r] = acc_r;
      fsel_nxt        = fsel_r ^ dec.imm;
    end
    if (dec.clock_mode) begin
      mode_nxt = acc_r;
    end
    if (dec.prescaler) begin
      pre_nxt = acc_r[0];
    end
    if (dec.lcd_three || dec.aux_timer || dec.ram_store ||
        dec.clock_mode || dec.prescaler) begin
      exec_cnt_nxt = exec_cnt_r + 8'h01;
    end
    // Software writes come after execution, so a bus write wins a tie
    if (wr_acc) begin
      case (paddr)
        ADDR_INSTR: begin
          instr_nxt = pwdata[9:0];
          exec_nxt  = 1'b1;
        end
        ADDR_ACC:       acc_nxt  = pwdata[3:0];
        ADDR_LCD_THREE: lcd_nxt  = pwdata[3:0];
        ADDR_AUX_COUNT: cnt_nxt  = pwdata[3:0];
        ADDR_AUX_RELD:  rld_nxt  = pwdata[3:0];
        ADDR_CLK_MODE:  mode_nxt = pwdata[3:0];
        ADDR_PRESCALE:  pre_nxt  = pwdata[0];
        ADDR_FILE_SEL:  fsel_nxt = pwdata[3:0];
        ADDR_DPTR:      dptr_nxt = pwdata[3:0];
        ADDR_RAM_DATA:  ram_nxt[dptr_r] = pwdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data and error answer
  // ----------------------------------------------------------------
  // Registered so prdata is a flop; the master samples it on the next access phase
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    err_nxt    = 1'b0;
    if (psel && !penable) begin
      case (paddr)
        ADDR_INSTR:     prdata_nxt = {22'h00_0000, instr_r};
        ADDR_ACC:       prdata_nxt = {28'h000_0000, acc_r};
        ADDR_LCD_THREE: prdata_nxt = {28'h000_0000, lcd_r};
        ADDR_AUX_COUNT: prdata_nxt = {28'h000_0000, cnt_r};
        ADDR_AUX_RELD:  prdata_nxt = {28'h000_0000, rld_r};
        ADDR_CLK_MODE:  prdata_nxt = {28'h000_0000, mode_r};
        ADDR_PRESCALE:  prdata_nxt = {31'h0000_0000, pre_r};
        ADDR_FILE_SEL:  prdata_nxt = {28'h000_0000, fsel_r};
        ADDR_DPTR:      prdata_nxt = {28'h000_0000, dptr_r};
        ADDR_RAM_DATA:  prdata_nxt = {28'h000_0000, ram_r[dptr_r]};
        ADDR_STATUS:    prdata_nxt = {23'h00_0000, exec_r, exec_cnt_r};
        default:        prdata_nxt = 32'h0000_0000;
      endcase
      err_nxt = !addr_ok;
    end else if (psel && penable) begin
      prdata_nxt = prdata_r;
      err_nxt    = err_r;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r      <= RST_NIBBLE;
      lcd_r      <= RST_NIBBLE;
      cnt_r      <= RST_NIBBLE;
      rld_r      <= RST_NIBBLE;
      mode_r     <= RST_NIBBLE;
      pre_r      <= 1'b0;
      fsel_r     <= RST_NIBBLE;
      dptr_r     <= RST_NIBBLE;
      instr_r    <= RST_INSTR;
      exec_r     <= 1'b0;
      exec_cnt_r <= 8'h00;
      prdata_r   <= 32'h0000_0000;
      err_r      <= 1'b0;
      for (int i = 0; i < RAM_DEPTH; i++) begin
        ram_r[i] <= RST_NIBBLE;
      end
    end else begin
      acc_r      <= acc_nxt;
      lcd_r      <= lcd_nxt;
      cnt_r      <= cnt_nxt;
      rld_r      <= rld_nxt;
      mode_r     <= mode_nxt;
      pre_r      <= pre_nxt;
      fsel_r     <= fsel_nxt;
      dptr_r     <= dptr_nxt;
      instr_r    <= instr_nxt;
      exec_r     <= exec_nxt;
      exec_cnt_r <= exec_cnt_nxt;
      prdata_r   <= prdata_nxt;
      err_r      <= err_nxt;
      ram_r      <= ram_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata             = prdata_r;
  assign pslverr            = err_r && psel && penable;
  assign lcd_ctrl_three     = lcd_r;
  assign aux_timer_count    = cnt_r;
  assign aux_timer_reload   = rld_r;
  assign clock_mode_reg     = mode_r;
  assign prescaler_ctrl_reg = pre_r;
  assign ram_file_select    = fsel_r;
  // This group never touches carry or skip
  assign carry_out          = 1'b0;
  assign skip_next          = 1'b0;

endmodule
`default_nettype wire

// [dv/atd_core_props.sv]
// Checker: port-level assertions for the accumulator transfer decoder
`timescale 1ns/1ps
`default_nettype none
module atd_core_props
  import atd_pkg::*;
#(
  parameter int RAM_DEPTH = RAM_WORDS
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  lcd_ctrl_three,
  input wire logic [3:0]  aux_timer_count,
  input wire logic [3:0]  aux_timer_reload,
  input wire logic [3:0]  clock_mode_reg,
  input wire logic        prescaler_ctrl_reg,
  input wire logic [3:0]  ram_file_select,
  input wire logic        carry_out,
  input wire logic        skip_next
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // Accumulator shadow, so expected results need no peek inside
  // ----------------------------------------------------------------
  logic       wr;
  logic       go;
  logic [3:0] acc_r;
  logic [3:0] acc_nxt;
  assign wr = psel && penable && pwrite;
  assign go = wr && paddr == ADDR_INSTR;
  always_comb begin
    acc_nxt = (wr && paddr == ADDR_ACC) ? pwdata[3:0] : acc_r;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) acc_r <= RST_NIBBLE;
    else acc_r <= acc_nxt;
  end
  // ----------------------------------------------------------------
  // Execution results; a quiet bus on the execute edge avoids overlap
  // ----------------------------------------------------------------
  a_lcd_copy: assert property (go && pwdata[9:0] == OP_LCD_THREE ##1 !wr |=>
    lcd_ctrl_three == $past(acc_r)) else $error("lcd control three not loaded");
  a_aux_count: assert property (go && pwdata[9:0] == OP_AUX_TIMER ##1 !wr |=>
    aux_timer_count == $past(acc_r)) else $error("aux timer count not loaded");
  a_aux_pair: assert property (go && pwdata[9:0] == OP_AUX_TIMER ##1 !wr |=>
    aux_timer_reload == $past(acc_r)) else $error("aux reload not loaded");
  a_store_xor: assert property (go && pwdata[9:4] == OP_STORE_HIGH ##1 !wr |=>
    ram_file_select == ($past(ram_file_select) ^ $past(pwdata[3:0], 2)))
    else $error("file select not xored with immediate");
  a_clk_mode: assert property (go && pwdata[9:0] == OP_CLOCK_MODE ##1 !wr |=>
    clock_mode_reg == $past(acc_r)) else $error("clock mode not loaded");
  a_prescale_bit: assert property (go && pwdata[9:0] == OP_PRESCALER ##1 !wr |=>
    prescaler_ctrl_reg == $past(acc_r[0])) else $error("prescaler bit not loaded");
  a_no_flags: assert property (go |=> ##1 !carry_out && !skip_next)
    else $error("carry or skip raised");
  a_err_unmapped: assert property (psel && penable && (paddr > ADDR_STATUS || paddr[1:0] != 2'h0)
    |-> pslverr && pready) else $error("unmapped access not flagged");
  a_ok_mapped: assert property (psel && penable && paddr <= ADDR_STATUS && paddr[1:0] == 2'h0
    |-> !pslverr && pready) else $error("mapped access flagged");
endmodule
bind atd_core atd_core_props #(.RAM_DEPTH(RAM_DEPTH)) atd_core_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .lcd_ctrl_three(lcd_ctrl_three), .aux_timer_count(aux_timer_count),
  .aux_timer_reload(aux_timer_reload), .clock_mode_reg(clock_mode_reg),
  .prescaler_ctrl_reg(prescaler_ctrl_reg), .ram_file_select(ram_file_select),
  .carry_out(carry_out), .skip_next(skip_next));
`default_nettype wire

// [dv/atd_core_bench.sv]
// Testbench: drives the transfer decoder over APB and checks every destination
`timescale 1ns/1ps
`default_nettype none
module atd_core_bench
  import atd_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, prescaler_ctrl_reg, carry_out, skip_next;
  logic [3:0] lcd_ctrl_three, aux_timer_count, aux_timer_reload, clock_mode_reg, ram_file_select;
  int mismatches = 0, tests_run = 0, cyc = 0;
  atd_core atd_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .lcd_ctrl_three(lcd_ctrl_three), .aux_timer_count(aux_timer_count),
    .aux_timer_reload(aux_timer_reload), .clock_mode_reg(clock_mode_reg),
    .prescaler_ctrl_reg(prescaler_ctrl_reg), .ram_file_select(ram_file_select),
    .carry_out(carry_out), .skip_next(skip_next));
  // ----------------------------------------------------------------
  // Clock, hang guard and shared helpers
  // ----------------------------------------------------------------
  always #50 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      mismatches++;
      $display("Error t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer taken at the completing edge, before any register moves
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(a, 1'b0, 32'h0, r, e);
    chk(r, x);
  endtask
  task automatic run_op(input logic [3:0] acc, input logic [9:0] op);
    wr(ADDR_ACC, {28'h0, acc});
    wr(ADDR_INSTR, {22'h0, op});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int a = 8; a <= 36; a += 4) rd(8'(a), 32'h0);
  endtask
  task automatic t_lcd_aux();
    run_op(4'hA, OP_LCD_THREE);
    rd(ADDR_LCD_THREE, 32'hA);
    chk(32'(lcd_ctrl_three), 32'hA);
    run_op(4'h5, OP_AUX_TIMER);
    rd(ADDR_AUX_COUNT, 32'h5);
    chk(32'(aux_timer_reload), 32'h5);
    rd(ADDR_ACC, 32'h5);
  endtask
  // Immediate 0 and F are the field's boundaries; file select accumulates the xors
  task automatic t_store();
    logic [3:0] fs;
    logic [3:0] j;
    fs = 4'h0;
    for (int k = 0; k < 3; k++) begin
      j = (k == 0) ? 4'h0 : ((k == 1) ? 4'h6 : 4'hF);
      wr(ADDR_DPTR, 32'(k + 3));
      run_op(~j, {OP_STORE_HIGH, j});
      fs ^= j;
      rd(ADDR_RAM_DATA, {28'h0, ~j});
      chk(32'(ram_file_select), {28'h0, fs});
    end
  endtask
  task automatic t_clk_pre();
    run_op(4'h3, OP_CLOCK_MODE);
    rd(ADDR_CLK_MODE, 32'h3);
    chk(32'(clock_mode_reg), 32'h3);
    run_op(4'hE, OP_PRESCALER);
    rd(ADDR_PRESCALE, 32'h0);
    run_op(4'h1, OP_PRESCALER);
    rd(ADDR_PRESCALE, 32'h1);
    chk(32'(prescaler_ctrl_reg), 32'h1);
    chk(32'({carry_out, skip_next}), 32'h0);
  endtask
  // Unmapped and misaligned places, and an opcode outside the group
  task automatic t_bus();
    logic [31:0] r;
    logic e;
    apb(8'h2C, 1'b1, 32'h5, r, e);
    chk(32'(e), 32'h1);
    apb(8'h06, 1'b0, 32'h0, r, e);
    chk(32'(e), 32'h1);
    run_op(4'h7, 10'h20E);
    rd(ADDR_STATUS, 32'h8);
    rd(ADDR_INSTR, 32'h20E);
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_lcd_aux();
    t_store();
    t_clk_pre();
    t_bus();
    print_verdict();
  end
endmodule
`default_nettype wire
